// file: logic/cca_ctl.sv
// Purpose: Controller end: turns register-port orders into instructions
// Assumes: Register port with read data one cycle after the read strobe
// Notes:   Refuses two-byte instructions to reserved addresses and slot writes during a call
module cca_ctl
    import cca_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       srst_i,
    input  wire logic       call_active_i,
    input  wire logic [1:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    cca_link_if.ctl         link
);
    typedef enum logic [1:0] {CTL_IDLE, CTL_SEL, CTL_SHIFT, CTL_END} cca_ctl_st_t;

    cca_ctl_st_t st_ff;
    logic [4:0]  div_ff;
    logic [4:0]  cnt_ff;
    logic [4:0]  nbits_ff;
    logic [15:0] shift_ff;
    logic [7:0]  wdata_ff;
    logic [7:0]  rdata_ff;
    logic        rd_ff;
    logic        sel_ff;
    logic        sclk_ff;
    logic        sdi_ff;
    logic        refused_ff;
    logic        done_ff;

    wire         busy_w     = (st_ff != CTL_IDLE);
    wire         tick_w     = busy_w && (div_ff == CTL_DIV_LAST);
    wire         cmd_wr_w   = reg_wr_i && (reg_addr_i == CR_CMD);
    wire  [3:0]  cmd_addr_w = reg_wdata_i[3:0];
    wire         cmd_sgl_w  = reg_wdata_i[CMD_SINGLE_BIT];
    wire         cmd_rd_w   = reg_wdata_i[CMD_READ_BIT];
    wire         ts_addr_w  = (cmd_addr_w == ADDR_TX_TS) || (cmd_addr_w == ADDR_RX_TS);
    wire         bad_rsvd_w = !cmd_sgl_w && cca_is_rsvd(cmd_addr_w);
    wire         bad_call_w = !cmd_sgl_w && !cmd_rd_w && ts_addr_w && call_active_i;
    wire         refuse_w   = cmd_wr_w && (busy_w || bad_rsvd_w || bad_call_w);
    wire         start_w    = cmd_wr_w && !refuse_w;
    wire         stat_rd_w  = reg_rd_i && (reg_addr_i == CR_STATUS);
    wire         finish_w   = tick_w && (st_ff == CTL_END);
    wire  [7:0]  status_w   = {5'h00, done_ff, refused_ff, busy_w};
    wire  [7:0]  rd_mux_w   = (reg_addr_i == CR_WDATA)  ? wdata_ff :
                              (reg_addr_i == CR_STATUS) ? status_w :
                              (reg_addr_i == CR_RDATA)  ? rdata_ff : 8'h00;

    assign link.sel  = sel_ff;
    assign link.sclk = sclk_ff;
    assign link.sdi  = sdi_ff;

    always_ff @(posedge mclk_i) begin
        if (srst_i || !busy_w || tick_w) begin
            div_ff <= 5'h00;
        end else begin
            div_ff <= div_ff + 5'h01;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            st_ff    <= CTL_IDLE;
            sel_ff   <= 1'b0;
            sclk_ff  <= 1'b0;
            sdi_ff   <= 1'b0;
            cnt_ff   <= 5'h00;
            nbits_ff <= 5'h00;
            shift_ff <= 16'h0000;
            rd_ff    <= 1'b0;
        end else begin
            sclk_ff <= 1'b0;
            case (st_ff)
                CTL_IDLE: begin
                    if (start_w) begin
                        shift_ff <= {reg_wdata_i[CMD_PWR_BIT], cmd_addr_w, cmd_rd_w,
                                     cmd_sgl_w, 1'b0, wdata_ff};
                        nbits_ff <= cmd_sgl_w ? BITS_ONE_BYTE : BITS_TWO_BYTE;
                        rd_ff    <= cmd_rd_w && !cmd_sgl_w;
                        cnt_ff   <= 5'h00;
                        sel_ff   <= 1'b1;
                        st_ff    <= CTL_SEL;
                    end
                end
                CTL_SEL: begin
                    if (tick_w) begin
                        st_ff <= CTL_SHIFT;
                    end
                end
                CTL_SHIFT: begin
                    if (tick_w) begin
                        if (cnt_ff == nbits_ff) begin
                            sel_ff <= 1'b0;
                            st_ff  <= CTL_END;
                        end else begin
                            sdi_ff   <= shift_ff[15];
                            sclk_ff  <= 1'b1;
                            shift_ff <= {shift_ff[14:0], 1'b0};
                            cnt_ff   <= cnt_ff + 5'h01;
                        end
                    end
                end
                CTL_END: begin
                    if (tick_w) begin
                        st_ff <= CTL_IDLE;
                    end
                end
                default: st_ff <= CTL_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            wdata_ff   <= 8'h00;
            rdata_ff   <= 8'h00;
            refused_ff <= 1'b0;
            done_ff    <= 1'b0;
        end else begin
            if (reg_wr_i && (reg_addr_i == CR_WDATA)) begin
                wdata_ff <= reg_wdata_i;
            end
            if (sclk_ff && rd_ff && (cnt_ff > BITS_ONE_BYTE)) begin
                rdata_ff <= {rdata_ff[6:0], link.sdo};
            end
            // Set beats the clear-on-read
            refused_ff <= refuse_w || (refused_ff && !stat_rd_w);
            done_ff    <= finish_w || (done_ff && !stat_rd_w);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= reg_rd_i ? rd_mux_w : 8'h00;
        end
    end
endmodule

// file: logic/cca_dev.sv
// Purpose: Codec end: decodes instructions, holds registers, gates PCM paths
// Assumes: frame_start_i and slot_strobe_i are one-cycle pulses on mclk
// Notes:   Register reset by srst_i or master_reset_pin_i, both synchronous
module cca_dev
    import cca_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       srst_i,
    input  wire logic       master_reset_pin_i,
    input  wire logic       frame_start_i,
    input  wire logic       slot_strobe_i,
    cca_link_if.dev         link,
    output logic      [1:0] dx_oe_o,
    output logic      [1:0] dr_en_o,
    output logic            receive_analog_output_en_o,
    output logic            pwr_up_o,
    output logic            fault_o,
    output logic            delayed_timing_o,
    output logic      [1:0] loop_mode_o,
    output logic            tx_sample_lost_o,
    output logic            rx_sample_lost_o,
    output logic      [7:0] hybrid_balance_first_o,
    output logic      [7:0] hybrid_balance_second_o,
    output logic      [7:0] hybrid_balance_third_o
);
    logic [7:0] reg_ff [16];
    logic [2:0] bit_cnt_ff;
    logic       byte_idx_ff;
    logic [6:0] shift_ff;
    logic [3:0] addr_ff;
    logic       rd_ff;
    logic       rsvd_ff;
    logic       pwr_ff;
    logic       fault_ff;
    logic [7:0] dout_ff;
    logic       sdo_oe_ff;
    logic [5:0] slot_ff;
    logic       tx_hold_ff;
    logic       tx_frm_ff;

    wire        rst_w       = srst_i || master_reset_pin_i;
    wire        bit_w       = link.sclk && link.sel;
    wire        byte_done_w = bit_w && (bit_cnt_ff == BIT_LAST);
    wire  [7:0] byte_w      = {shift_ff, link.sdi};
    wire  [3:0] b1_addr_w   = byte_w[ADDR_MSB:ADDR_LSB];
    wire        b1_rsvd_w   = cca_is_rsvd(b1_addr_w);
    wire        b1_single_w = byte_w[SINGLE_BIT];
    wire        b1_read_w   = byte_w[READ_BIT];
    wire        b1_done_w   = byte_done_w && !byte_idx_ff;
    wire        b2_done_w   = byte_done_w && byte_idx_ff;
    wire        wr_commit_w = b2_done_w && !rd_ff && !rsvd_ff;
    wire  [7:0] rd_sel_w    = b1_rsvd_w ? 8'h00 : reg_ff[b1_addr_w];

    wire        tx_ts_wr_w  = wr_commit_w && (addr_ff == ADDR_TX_TS);
    wire        rx_ts_wr_w  = wr_commit_w && (addr_ff == ADDR_RX_TS);

    wire  [7:0] ctrl_w      = reg_ff[ADDR_CONTROL];
    wire  [7:0] tx_ts_w     = reg_ff[ADDR_TX_TS];
    wire  [7:0] rx_ts_w     = reg_ff[ADDR_RX_TS];
    wire  [1:0] loop_w      = ctrl_w[CTRL_LOOP_MSB:CTRL_LOOP_LSB];
    wire        live_w      = pwr_ff && !fault_ff;
    wire        tx_slot_w   = (slot_ff == tx_ts_w[TS_SLOT_MSB:0]);
    wire        rx_slot_w   = (slot_ff == rx_ts_w[TS_SLOT_MSB:0]);
    wire        tx_gain_on_w = (reg_ff[ADDR_TX_GAIN] != GAIN_OFF);
    wire        rx_gain_on_w = (reg_ff[ADDR_RX_GAIN] != GAIN_OFF);
    wire        tx_conn_w   = live_w && tx_ts_w[TS_EN_BIT] && tx_gain_on_w;
    wire        rx_conn_w   = live_w && rx_ts_w[TS_EN_BIT];
    wire        tx_ok_w     = tx_conn_w && (loop_w == LOOP_NORMAL) && !tx_hold_ff
                              && !tx_ts_wr_w;
    // rx only off in write cycle
    wire        rx_ok_w     = rx_conn_w && !rx_ts_wr_w;
    wire  [1:0] tx_port_w   = tx_ts_w[TS_PORT_BIT] ? 2'h2 : 2'h1;
    wire  [1:0] rx_port_w   = rx_ts_w[TS_PORT_BIT] ? 2'h2 : 2'h1;
    wire  [1:0] nxt_dx_oe   = (tx_ok_w && tx_slot_w) ? tx_port_w : 2'h0;
    wire  [1:0] nxt_dr_en   = (rx_ok_w && rx_slot_w) ? rx_port_w : 2'h0;
    wire        tx_release_w = tx_hold_ff && frame_start_i && tx_frm_ff && !tx_ts_wr_w;

    assign link.sdo    = dout_ff[7];
    assign link.sdo_oe = sdo_oe_ff;

    // Bit and byte framing; deselect always realigns
    always_ff @(posedge mclk_i) begin
        if (rst_w || !link.sel) begin
            bit_cnt_ff  <= 3'h0;
            byte_idx_ff <= 1'b0;
        end else if (bit_w) begin
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            if (b1_done_w) begin
                // single byte leaves count at zero
                byte_idx_ff <= !b1_single_w;
            end else if (b2_done_w) begin
                byte_idx_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_w) begin
            shift_ff <= 7'h00;
            addr_ff  <= 4'h0;
            rd_ff    <= 1'b0;
            rsvd_ff  <= 1'b0;
        end else begin
            if (bit_w) begin
                shift_ff <= byte_w[6:0];
            end
            if (b1_done_w) begin
                addr_ff <= b1_addr_w;
                rd_ff   <= b1_read_w;
                rsvd_ff <= b1_rsvd_w;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_w) begin
            for (int i = 0; i < 16; i++) begin
                reg_ff[i] <= REG_RESET;
            end
        end else if (wr_commit_w) begin
            reg_ff[addr_ff] <= byte_w;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_w) begin
            pwr_ff   <= 1'b0;
            fault_ff <= 1'b0;
        end else if (b1_done_w) begin
            pwr_ff <= !byte_w[PWR_BIT];
            if (byte_w[PWR_BIT]) begin
                fault_ff <= 1'b0;
            end else if (b1_rsvd_w && !b1_single_w) begin
                fault_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_w) begin
            dout_ff   <= 8'h00;
            sdo_oe_ff <= 1'b0;
        end else if (b1_done_w && b1_read_w && !b1_single_w) begin
            dout_ff   <= rd_sel_w;
            sdo_oe_ff <= 1'b1;
        end else if (b2_done_w || !link.sel) begin
            dout_ff   <= 8'h00;
            sdo_oe_ff <= 1'b0;
        end else if (bit_w && byte_idx_ff) begin
            dout_ff <= {dout_ff[6:0], 1'b0};
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_w || frame_start_i) begin
            slot_ff <= 6'h00;
        end else if (slot_strobe_i) begin
            slot_ff <= slot_ff + 6'h01;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_w) begin
            tx_hold_ff <= 1'b0;
            tx_frm_ff  <= 1'b0;
        end else if (tx_ts_wr_w) begin
            tx_hold_ff <= 1'b1;
            tx_frm_ff  <= 1'b0;
        end else if (tx_hold_ff && frame_start_i) begin
            tx_hold_ff <= !tx_frm_ff;
            tx_frm_ff  <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_w) begin
            dx_oe_o          <= 2'h0;
            dr_en_o          <= 2'h0;
            tx_sample_lost_o <= 1'b0;
            rx_sample_lost_o <= 1'b0;
        end else begin
            dx_oe_o          <= nxt_dx_oe;
            dr_en_o          <= nxt_dr_en;
            tx_sample_lost_o <= tx_release_w && tx_conn_w;
            rx_sample_lost_o <= rx_ts_wr_w && rx_conn_w && rx_slot_w;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_w) begin
            receive_analog_output_en_o <= 1'b0;
            pwr_up_o                   <= 1'b0;
            fault_o                    <= 1'b0;
            delayed_timing_o           <= 1'b0;
            loop_mode_o                <= LOOP_NORMAL;
            hybrid_balance_first_o     <= REG_RESET;
            hybrid_balance_second_o    <= REG_RESET;
            hybrid_balance_third_o     <= REG_RESET;
        end else begin
            receive_analog_output_en_o <= rx_conn_w && rx_gain_on_w;
            pwr_up_o                   <= pwr_ff;
            fault_o                    <= fault_ff;
            delayed_timing_o           <= ctrl_w[CTRL_DELAY_BIT];
            loop_mode_o                <= loop_w;
            hybrid_balance_first_o     <= reg_ff[ADDR_HYBAL_1];
            hybrid_balance_second_o    <= reg_ff[ADDR_HYBAL_2];
            hybrid_balance_third_o     <= reg_ff[ADDR_HYBAL_3];
        end
    end
endmodule

// file: logic/cca_link_if.sv
// Purpose: Serial control port between controller and codec
// Assumes: sclk is a one-cycle bit strobe on mclk, sdi valid beside it
// Notes:   Device drives sdo at all times and holds it low while sdo_oe is low
interface cca_link_if;
    logic sel;
    logic sclk;
    logic sdi;
    logic sdo;
    logic sdo_oe;

    modport dev (
        input  sel,
        input  sclk,
        input  sdi,
        output sdo,
        output sdo_oe
    );

    modport ctl (
        output sel,
        output sclk,
        output sdi,
        input  sdo,
        input  sdo_oe
    );
endinterface

// file: logic/cca_pkg.sv
// Purpose: Shared constants for codec control register access, both ends
// Assumes: Instruction byte 1 = {pwr_down, addr[3:0], read, single, 0}
// Notes:   Byte 2 carries write data or returns read data, MSB first
package cca_pkg;
    localparam int          CLK_MHZ        = 200;
    localparam int          BIT_TIME_NS    = 100;
    localparam int          CTL_DIV        = (BIT_TIME_NS * CLK_MHZ) / 1000;
    localparam logic [4:0]  CTL_DIV_LAST   = 5'(CTL_DIV - 1);

    localparam logic [2:0]  BIT_LAST       = 3'h7;
    localparam logic [4:0]  BITS_ONE_BYTE  = 5'h08;
    localparam logic [4:0]  BITS_TWO_BYTE  = 5'h10;

    localparam int          PWR_BIT        = 7;
    localparam int          ADDR_MSB       = 6;
    localparam int          ADDR_LSB       = 3;
    localparam int          READ_BIT       = 2;
    localparam int          SINGLE_BIT     = 1;

    localparam logic [3:0]  ADDR_CONTROL   = 4'h0;
    localparam logic [3:0]  ADDR_LATCH_DIR = 4'h1;
    localparam logic [3:0]  ADDR_LATCH_VAL = 4'h2;
    localparam logic [3:0]  ADDR_RSVD_LOW  = 4'h3;
    localparam logic [3:0]  ADDR_TX_GAIN   = 4'h4;
    localparam logic [3:0]  ADDR_RX_GAIN   = 4'h5;
    localparam logic [3:0]  ADDR_HYBAL_1   = 4'h6;
    localparam logic [3:0]  ADDR_HYBAL_2   = 4'h7;
    localparam logic [3:0]  ADDR_HYBAL_3   = 4'h8;
    localparam logic [3:0]  ADDR_TX_TS     = 4'h9;
    localparam logic [3:0]  ADDR_RX_TS     = 4'hA;
    localparam logic [3:0]  ADDR_RSVD_HIGH = 4'hB;

    localparam int          CTRL_DELAY_BIT = 3;
    localparam int          CTRL_LOOP_MSB  = 2;
    localparam int          CTRL_LOOP_LSB  = 1;
    localparam logic [1:0]  LOOP_NORMAL    = 2'h0;

    localparam int          TS_EN_BIT      = 7;
    localparam int          TS_PORT_BIT    = 6;
    localparam int          TS_SLOT_MSB    = 5;

    localparam logic [7:0]  REG_RESET      = 8'h00;
    localparam logic [7:0]  GAIN_OFF       = 8'h00;

    localparam logic [1:0]  CR_CMD         = 2'h0;
    localparam logic [1:0]  CR_WDATA       = 2'h1;
    localparam logic [1:0]  CR_STATUS      = 2'h2;
    localparam logic [1:0]  CR_RDATA       = 2'h3;
    localparam int          CMD_READ_BIT   = 4;
    localparam int          CMD_PWR_BIT    = 5;
    localparam int          CMD_SINGLE_BIT = 6;

    function automatic logic cca_is_rsvd(input logic [3:0] a);
        return (a == ADDR_RSVD_LOW) || (a >= ADDR_RSVD_HIGH);
    endfunction
endpackage

// file: verification/cca_chk.sv
// Purpose: Link framing and PCM gating checks for codec control access
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Instantiated beside the link interface, no bind
module cca_chk
    import cca_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       srst_i,
    input  wire logic       sel,
    input  wire logic       sclk,
    input  wire logic       sdo_oe,
    input  wire logic       frame_start_i,
    input  wire logic [1:0] dx_oe_o,
    input  wire logic [1:0] dr_en_o,
    input  wire logic       pwr_up_o,
    input  wire logic       fault_o,
    input  wire logic [1:0] loop_mode_o,
    input  wire logic       tx_sample_lost_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (srst_i);

    a_sclk_framed: assert property (sclk |-> sel)
        else $error("bit strobe outside a frame");
    a_sclk_pulse: assert property (sclk |=> !sclk)
        else $error("bit strobe longer than one cycle");
    a_oe_released: assert property ($fell(sel) |=> !sdo_oe)
        else $error("read drive kept after frame end");
    a_loop_mutes_tx: assert property (
        (loop_mode_o != LOOP_NORMAL) && $past(loop_mode_o != LOOP_NORMAL) |-> dx_oe_o == 2'h0)
        else $error("tx driven in loopback");
    a_fault_mutes: assert property (
        fault_o && $past(fault_o) |-> (dx_oe_o == 2'h0) && (dr_en_o == 2'h0))
        else $error("pcm path active during fault");
    a_down_mutes: assert property (
        !pwr_up_o && !$past(pwr_up_o) |-> (dx_oe_o == 2'h0) && (dr_en_o == 2'h0))
        else $error("pcm path active while powered down");
    a_one_port: assert property ($onehot0(dx_oe_o) && $onehot0(dr_en_o))
        else $error("both pcm ports enabled");
    a_lost_single: assert property (tx_sample_lost_o |=> !tx_sample_lost_o)
        else $error("tx loss pulse too long");
    a_lost_at_frame: assert property (
        tx_sample_lost_o |-> $past(frame_start_i) || $past(frame_start_i, 2))
        else $error("tx release away from frame start");
endmodule

// file: verification/tb_codec_control_register_access.sv
// Purpose: Self-checking bench joining controller and codec ends
// Assumes: Frame of 256 cycles, slot strobe every 8 cycles
// Notes:   Counts tx/rx loss pulses and frames since the last bit of each two-byte instruction
module tb_codec_control_register_access
    import cca_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic       mclk_i = 1'b0;
    logic       srst_i = 1'b1;
    logic       call_active_i = 1'b0;
    logic       master_reset_pin_i = 1'b0;
    logic       reg_wr_i = 1'b0;
    logic       reg_rd_i = 1'b0;
    logic [1:0] reg_addr_i = 2'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic       frame_start_i = 1'b0;
    logic       slot_strobe_i = 1'b0;
    logic [7:0] fcnt = 8'h00;
    logic [7:0] reg_rdata_o;
    logic [7:0] hb [3];
    logic [1:0] dx_oe_o, dr_en_o, loop_mode_o;
    logic       ra_en, pwr_up_o, fault_o, dly, tx_lost, rx_lost;
    int         errors = 0, tests_run = 0, nbits = 0, nfr = 0, ntx = 0, nrx = 0;

    always #2.5 mclk_i = ~mclk_i;

    cca_link_if i_cca_link_if ();
    cca_ctl i_cca_ctl (.mclk_i(mclk_i), .srst_i(srst_i), .call_active_i(call_active_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .link(i_cca_link_if));
    cca_dev i_cca_dev (.mclk_i(mclk_i), .srst_i(srst_i), .master_reset_pin_i(master_reset_pin_i),
        .frame_start_i(frame_start_i), .slot_strobe_i(slot_strobe_i), .link(i_cca_link_if),
        .dx_oe_o(dx_oe_o), .dr_en_o(dr_en_o), .receive_analog_output_en_o(ra_en),
        .pwr_up_o(pwr_up_o), .fault_o(fault_o), .delayed_timing_o(dly),
        .loop_mode_o(loop_mode_o), .tx_sample_lost_o(tx_lost), .rx_sample_lost_o(rx_lost),
        .hybrid_balance_first_o(hb[0]), .hybrid_balance_second_o(hb[1]),
        .hybrid_balance_third_o(hb[2]));
    cca_chk i_cca_chk (.mclk_i(mclk_i), .srst_i(srst_i), .sel(i_cca_link_if.sel),
        .sclk(i_cca_link_if.sclk), .sdo_oe(i_cca_link_if.sdo_oe),
        .frame_start_i(frame_start_i), .dx_oe_o(dx_oe_o), .dr_en_o(dr_en_o),
        .pwr_up_o(pwr_up_o), .fault_o(fault_o), .loop_mode_o(loop_mode_o),
        .tx_sample_lost_o(tx_lost));

    always @(posedge mclk_i) begin
        fcnt <= fcnt + 8'h01;
        frame_start_i <= (fcnt == 8'hFF);
        slot_strobe_i <= (fcnt[2:0] == 3'h3);
        nbits <= !i_cca_link_if.sel ? 0 : nbits + int'(i_cca_link_if.sclk);
        nfr <= (i_cca_link_if.sel && i_cca_link_if.sclk && nbits == 15) ? 0
             : nfr + int'(frame_start_i);
        ntx <= ntx + int'(tx_lost === 1'b1);
        nrx <= nrx + int'(rx_lost === 1'b1);
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask

    // One instruction: a address, r read, p power-down, s single byte
    task automatic instr(input logic [3:0] a, input logic r, input logic p, input logic s,
                         input logic [7:0] d, output logic [7:0] st);
        int n;
        wr(2'h1, d);
        wr(2'h0, {1'b0, s, p, r, a});
        for (n = 0; n < 1000; n++) begin
            rd(2'h2, st);
            if (st[2] || st[1]) break;
        end
        if (n == 1000) begin
            errors++;
            test_done();
        end
    endtask

    task automatic watch(output logic [1:0] dx, output logic [1:0] dr);
        dx = 2'h0;
        dr = 2'h0;
        repeat (260) begin
            @(posedge mclk_i);
            #1;
            dx |= dx_oe_o;
            dr |= dr_en_o;
        end
    endtask

    task automatic sc_reset_regs;
        logic [7:0] st;
        check("power", 8'(pwr_up_o), 8'h00);
        check("balance1", hb[0], REG_RESET);
        instr(ADDR_HYBAL_1, 1'b0, 1'b0, 1'b0, 8'h5A, st);
        check("balance1", hb[0], 8'h5A);
        @(posedge mclk_i);
        master_reset_pin_i <= 1'b1;
        @(posedge mclk_i);
        master_reset_pin_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        #1 check("balance1", hb[0], REG_RESET);
        check("power", 8'(pwr_up_o), 8'h00);
    endtask

    task automatic sc_balance;
        logic [7:0] st, d;
        for (int i = 0; i < 3; i++) begin
            instr(ADDR_HYBAL_1 + 4'(i), 1'b0, 1'b0, 1'b0, 8'hA1 + 8'(i), st);
        end
        for (int i = 0; i < 3; i++) begin
            check("balance", hb[i], 8'hA1 + 8'(i));
            instr(ADDR_HYBAL_1 + 4'(i), 1'b1, 1'b0, 1'b0, 8'h00, st);
            rd(2'h3, d);
            check("readback", d, 8'hA1 + 8'(i));
        end
    endtask

    task automatic sc_reserved;
        logic [7:0] st;
        for (int i = 0; i < 6; i++) begin
            instr((i == 0) ? ADDR_RSVD_LOW : ADDR_RSVD_HIGH + 4'(i - 1), 1'b0, 1'b0, 1'b0,
                  8'hFF, st);
            check("refused", 8'(st[1]), 8'h01);
        end
        check("balance3", hb[2], 8'hA3);
        check("fault", 8'(fault_o), 8'h00);
    endtask

    task automatic sc_power;
        logic [7:0] st;
        instr(ADDR_CONTROL, 1'b0, 1'b1, 1'b1, 8'h00, st);
        check("power", 8'(pwr_up_o), 8'h00);
        instr(ADDR_CONTROL, 1'b0, 1'b0, 1'b1, 8'h00, st);
        check("power", 8'(pwr_up_o), 8'h01);
    endtask

    task automatic sc_tx_slot;
        logic [7:0] st;
        logic [1:0] dx, dr;
        int         t0, n;
        instr(ADDR_TX_GAIN, 1'b0, 1'b0, 1'b0, 8'h40, st);
        instr(ADDR_TX_TS, 1'b0, 1'b0, 1'b0, 8'h85, st);
        repeat (600) @(posedge mclk_i);
        watch(dx, dr);
        check("tx_port0", 8'(dx), 8'h01);
        t0 = ntx;
        instr(ADDR_TX_TS, 1'b0, 1'b0, 1'b0, 8'hC5, st);
        for (n = 0; n < 1000 && dx_oe_o === 2'h0; n++) begin
            @(posedge mclk_i);
            #1;
        end
        if (n == 1000) begin
            errors++;
            test_done();
        end
        check("frames_held", 8'(nfr), 8'h02);
        check("tx_port1", 8'(dx_oe_o), 8'h02);
        check("tx_lost", 8'(ntx - t0), 8'h01);
    endtask

    task automatic sc_read_keeps;
        logic [7:0] st, d;
        logic [1:0] dx, dr;
        int         t0, r0;
        t0 = ntx;
        r0 = nrx;
        instr(ADDR_TX_TS, 1'b1, 1'b0, 1'b0, 8'h00, st);
        rd(2'h3, d);
        check("tx_slot", d, 8'hC5);
        watch(dx, dr);
        check("tx_kept", 8'(dx), 8'h02);
        check("no_loss", 8'(ntx - t0), 8'h00);
        check("no_rx_loss", 8'(nrx - r0), 8'h00);
    endtask

    task automatic sc_rx_slot;
        logic [7:0] st;
        logic [1:0] dx, dr;
        instr(ADDR_RX_GAIN, 1'b0, 1'b0, 1'b0, 8'h30, st);
        instr(ADDR_RX_TS, 1'b0, 1'b0, 1'b0, 8'hC3, st);
        watch(dx, dr);
        check("rx_port1", 8'(dr), 8'h02);
        check("rx_out", 8'(ra_en), 8'h01);
        instr(ADDR_RX_TS, 1'b0, 1'b0, 1'b0, 8'h43, st);
        watch(dx, dr);
        check("rx_off", 8'(dr), 8'h00);
        check("rx_out", 8'(ra_en), 8'h00);
    endtask

    task automatic sc_mute;
        logic [7:0] st;
        logic [1:0] dx, dr;
        for (int i = 1; i < 4; i++) begin
            instr(ADDR_CONTROL, 1'b0, 1'b0, 1'b0, {5'h00, 2'(i), 1'b0}, st);
            watch(dx, dr);
            check("loop", 8'(loop_mode_o), 8'(i));
            check("tx_looped", 8'(dx), 8'h00);
        end
        instr(ADDR_CONTROL, 1'b0, 1'b0, 1'b0, 8'h08, st);
        watch(dx, dr);
        check("delayed", 8'(dly), 8'h01);
        check("tx_normal", 8'(dx), 8'h02);
        instr(ADDR_TX_GAIN, 1'b0, 1'b0, 1'b0, GAIN_OFF, st);
        watch(dx, dr);
        check("tx_gain_off", 8'(dx), 8'h00);
    endtask

    task automatic sc_call_refuse;
        logic [7:0] st, d;
        @(posedge mclk_i);
        call_active_i <= 1'b1;
        instr(ADDR_TX_TS, 1'b0, 1'b0, 1'b0, 8'h85, st);
        check("refused", 8'(st[1]), 8'h01);
        instr(ADDR_TX_TS, 1'b1, 1'b0, 1'b0, 8'h00, st);
        check("read_done", 8'(st[2]), 8'h01);
        rd(2'h3, d);
        check("tx_slot", d, 8'hC5);
        @(posedge mclk_i);
        call_active_i <= 1'b0;
    endtask

    initial begin
        repeat (4) @(posedge mclk_i);
        srst_i <= 1'b0;
        @(posedge mclk_i);
        #1;
        sc_reset_regs();
        sc_balance();
        sc_reserved();
        sc_power();
        sc_tx_slot();
        sc_read_keeps();
        sc_rx_slot();
        sc_mute();
        sc_call_refuse();
        test_done();
    end
endmodule
